// >>> dssf_regs.vh
`ifndef DSSF_REGS_VH
`define DSSF_REGS_VH
// ----------------------------------------------------------------------------
// Frame lengths
// ----------------------------------------------------------------------------
`define DSSF_SQ_BITS      16
`define DSSF_SAT_BITS     80
// ----------------------------------------------------------------------------
// Squib port words
// ----------------------------------------------------------------------------
`define DSSF_SQ_FAULT     16'hD009
`define DSSF_SQ_RST_CMD   16'hFFAA
`define DSSF_SQ_RESET_VAL 16'h0000
// ----------------------------------------------------------------------------
// Satellite status response frame: length fault bit position
// ----------------------------------------------------------------------------
`define DSSF_SAT_LEN_BIT  79
// ----------------------------------------------------------------------------
// Pin idle levels: serial clocks low, chip selects high
// ----------------------------------------------------------------------------
`define DSSF_PIN_IDLE     4'h5
`endif

// >>> dssf_spi.v
`timescale 1ns/1ps
`include "dssf_regs.vh"
// Operation
// RULE1 - Two independent slave ports, squib and satellite, usable at the same time.
// RULE2 - Squib port serves squib functions; satellite port serves satellite functions.
// RULE3 - Squib port software reset clears squib and satellite functions alike.
// RULE4 - Each port counts clock rising edges while selected for a length check.
// RULE5 - Squib frame not exactly 16 edges is discarded and answered by fault.
// RULE6 - Satellite frame not exactly 80 edges is discarded and flagged in status.
// RULE7 - Beyond 16 edges the squib output holds the sixteenth bit level.
// RULE8 - Beyond 80 edges the satellite output holds the eightieth bit level.
// RULE9 - Chip selects are active low; either or both may be asserted anytime.
// RULE10 - On select, enable the output driver and load status into shifter.
// RULE11 - While deselected, the data output stays in high impedance.
// RULE12 - One bit in and one bit out per serial clock cycle.
// RULE13 - Master and device sample incoming data on the rising clock edge.
// RULE14 - Device changes its outgoing bit on the falling clock edge.
// RULE15 - Device sends each word most significant bit first.
// RULE16 - Master sends each word most significant bit first.
// RULE17 - Squib reply appears during the following transfer, not the same one.
// RULE18 - A fixed fault word is loaded for the transfer after a length error.
module dssf_spi #(
  parameter SQ_BITS  = `DSSF_SQ_BITS,
  parameter SAT_BITS = `DSSF_SAT_BITS
) (
  // System
  input  wire                SYS_CLK,
  input  wire                RST_N,
  // Squib port pins
  input  wire                SQ_SCLK,
  input  wire                SQ_CS_N,
  input  wire                SQ_MOSI,
  output reg                 SQ_MISO_O,
  output reg                 SQ_MISO_OE,
  // Satellite port pins
  input  wire                SAT_SCLK,
  input  wire                SAT_CS_N,
  input  wire                SAT_MOSI,
  output reg                 SAT_MISO_O,
  output reg                 SAT_MISO_OE,
  // Squib function side
  input  wire [SQ_BITS-1:0]  SQ_REPLY,
  output reg  [SQ_BITS-1:0]  SQ_CMD,
  output reg                 SQ_CMD_VLD,
  // Satellite function side
  input  wire [SAT_BITS-1:0] SAT_STATUS,
  output reg  [SAT_BITS-1:0] SAT_CMD,
  output reg                 SAT_CMD_VLD,
  // Soft reset to squib and satellite functions
  output reg                 SOFT_RST
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  reg [3:0] meta_r;
  reg [3:0] sync_r;
  reg [3:0] sync_d_r;

  // RULE1 - separate synchronisers
  // Reset to the idle pin levels, so that release of reset shows no false clock edge.
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      meta_r   <= `DSSF_PIN_IDLE;
      sync_r   <= `DSSF_PIN_IDLE;
      sync_d_r <= `DSSF_PIN_IDLE;
    end else begin
      meta_r   <= {SQ_SCLK, SQ_CS_N, SAT_SCLK, SAT_CS_N};
      sync_r   <= meta_r;
      sync_d_r <= sync_r;
    end
  end

  reg [1:0] mosi_meta_r;
  reg [1:0] mosi_r;

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      mosi_meta_r <= 2'h0;
      mosi_r      <= 2'h0;
    end else begin
      mosi_meta_r <= {SQ_MOSI, SAT_MOSI};
      mosi_r      <= mosi_meta_r;
    end
  end

  // RULE9 - active low selects
  wire sq_sel     = ~sync_r[2];
  wire sq_sel_on  = ~sync_r[2] & sync_d_r[2];
  wire sq_sel_off = sync_r[2] & ~sync_d_r[2];
  // RULE13 - rising edge sampling
  wire sq_rise    = sync_r[3] & ~sync_d_r[3];
  // RULE14 - falling edge shifting
  wire sq_fall    = ~sync_r[3] & sync_d_r[3];
  wire sat_sel     = ~sync_r[0];
  wire sat_sel_on  = ~sync_r[0] & sync_d_r[0];
  wire sat_sel_off = sync_r[0] & ~sync_d_r[0];
  wire sat_rise    = sync_r[1] & ~sync_d_r[1];
  wire sat_fall    = ~sync_r[1] & sync_d_r[1];

  // --------------------------------------------------------------------------
  // Squib port
  // --------------------------------------------------------------------------
  reg [SQ_BITS-1:0] sq_tx_r;
  reg [SQ_BITS-1:0] sq_rx_r;
  reg [SQ_BITS-1:0] sq_reply_r;
  reg [7:0]         sq_cnt_r;
  reg               sq_err_r;
  wire [SQ_BITS-1:0] sq_load = sq_err_r ? `DSSF_SQ_FAULT : sq_reply_r;

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      sq_tx_r    <= `DSSF_SQ_RESET_VAL;
      sq_rx_r    <= `DSSF_SQ_RESET_VAL;
      sq_reply_r <= `DSSF_SQ_RESET_VAL;
      sq_cnt_r   <= 8'h00;
      sq_err_r   <= 1'b0;
      SQ_MISO_O  <= 1'b0;
      SQ_MISO_OE <= 1'b0;
      SQ_CMD     <= `DSSF_SQ_RESET_VAL;
      SQ_CMD_VLD <= 1'b0;
      SOFT_RST   <= 1'b0;
    end else begin
      SQ_CMD_VLD <= 1'b0;
      SOFT_RST   <= 1'b0;
      if (sq_sel_on) begin
        // RULE10 - load and enable
        SQ_MISO_OE <= 1'b1;
        sq_cnt_r   <= 8'h00;
        // RULE17 - previous reply
        // RULE18 - fault word
        sq_tx_r    <= sq_load;
        SQ_MISO_O  <= sq_load[SQ_BITS-1];
      end else if (sq_sel) begin
        // RULE4 - count rising edges
        if (sq_rise) begin
          if (sq_cnt_r != 8'hFF) sq_cnt_r <= sq_cnt_r + 8'h01;
          // RULE12 - one bit in
          // RULE16 - MSB first input
          sq_rx_r <= {sq_rx_r[SQ_BITS-2:0], mosi_r[1]};
        end
        // RULE7 - hold sixteenth bit
        if (sq_fall && sq_cnt_r < SQ_BITS) begin
          // RULE15 - MSB first output
          sq_tx_r   <= {sq_tx_r[SQ_BITS-2:0], 1'b0};
          SQ_MISO_O <= sq_tx_r[SQ_BITS-2];
        end
      end
      if (sq_sel_off) begin
        // RULE11 - release output
        SQ_MISO_OE <= 1'b0;
        // RULE5 - length check
        if (sq_cnt_r == SQ_BITS) begin
          sq_err_r <= 1'b0;
          // RULE3 - global soft reset
          if (sq_rx_r == `DSSF_SQ_RST_CMD) SOFT_RST <= 1'b1;
          // RULE2 - pass command on
          else begin
            SQ_CMD     <= sq_rx_r;
            SQ_CMD_VLD <= 1'b1;
          end
        end else begin
          sq_err_r <= 1'b1;
        end
      end
      if (SQ_CMD_VLD) sq_reply_r <= SQ_REPLY;
    end
  end

  // --------------------------------------------------------------------------
  // Satellite port
  // --------------------------------------------------------------------------
  reg [SAT_BITS-1:0] sat_tx_r;
  reg [SAT_BITS-1:0] sat_rx_r;
  reg [7:0]          sat_cnt_r;
  reg                sat_err_r;
  wire [SAT_BITS-1:0] sat_load = SAT_STATUS |
                                 ({{(SAT_BITS-1){1'b0}}, sat_err_r} << `DSSF_SAT_LEN_BIT);

  always @(posedge SYS_CLK) begin
    if (!RST_N || SOFT_RST) begin
      sat_tx_r    <= {SAT_BITS{1'b0}};
      sat_rx_r    <= {SAT_BITS{1'b0}};
      sat_cnt_r   <= 8'h00;
      sat_err_r   <= 1'b0;
      SAT_MISO_O  <= 1'b0;
      SAT_MISO_OE <= 1'b0;
      SAT_CMD     <= {SAT_BITS{1'b0}};
      SAT_CMD_VLD <= 1'b0;
    end else begin
      SAT_CMD_VLD <= 1'b0;
      if (sat_sel_on) begin
        // RULE10 - capture status
        // RULE6 - fault in status frame
        SAT_MISO_OE <= 1'b1;
        sat_cnt_r   <= 8'h00;
        sat_tx_r    <= sat_load;
        SAT_MISO_O  <= sat_load[SAT_BITS-1];
      end else if (sat_sel) begin
        if (sat_rise) begin
          if (sat_cnt_r != 8'hFF) sat_cnt_r <= sat_cnt_r + 8'h01;
          sat_rx_r <= {sat_rx_r[SAT_BITS-2:0], mosi_r[0]};
        end
        // RULE8 - hold eightieth bit
        if (sat_fall && sat_cnt_r < SAT_BITS) begin
          sat_tx_r   <= {sat_tx_r[SAT_BITS-2:0], 1'b0};
          SAT_MISO_O <= sat_tx_r[SAT_BITS-2];
        end
      end
      if (sat_sel_off) begin
        SAT_MISO_OE <= 1'b0;
        if (sat_cnt_r == SAT_BITS) begin
          sat_err_r   <= 1'b0;
          SAT_CMD     <= sat_rx_r;
          SAT_CMD_VLD <= 1'b1;
        end else begin
          sat_err_r <= 1'b1;
        end
      end
    end
  end

endmodule

// >>> dssf_spi_assertions.sv
`timescale 1ns/1ps
module dssf_chk (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic SQ_CS_N,
  input wire logic SQ_MISO_OE,
  input wire logic SQ_CMD_VLD,
  input wire logic SOFT_RST,
  input wire logic SAT_CS_N,
  input wire logic SAT_MISO_OE,
  input wire logic SAT_CMD_VLD
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  sq_oe_on_a: assert property (!SQ_CS_N [*5] |-> SQ_MISO_OE)
    else $error("squib driver not enabled while selected");
  sq_oe_off_a: assert property (SQ_CS_N [*5] |-> !SQ_MISO_OE)
    else $error("squib driver on while deselected");
  sat_oe_on_a: assert property (!SAT_CS_N [*5] |-> SAT_MISO_OE)
    else $error("satellite driver not enabled while selected");
  sat_oe_off_a: assert property (SAT_CS_N [*5] |-> !SAT_MISO_OE)
    else $error("satellite driver on while deselected");
  sq_vld_end_a: assert property (SQ_CMD_VLD |-> SQ_CS_N && $past(SQ_CS_N, 3))
    else $error("squib command before frame end");
  soft_rst_a: assert property (SOFT_RST |-> !SQ_CMD_VLD && $past(SQ_CS_N, 3))
    else $error("soft reset out of place");
  sat_vld_end_a: assert property (SAT_CMD_VLD |-> SAT_CS_N && $past(SAT_CS_N, 3))
    else $error("satellite command before frame end");
  sat_oe_fall_a: assert property ($fell(SAT_MISO_OE) |-> $past(SAT_CS_N, 2))
    else $error("satellite driver dropped while selected");
endmodule
bind dssf_spi dssf_chk i_dssf_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .SQ_CS_N(SQ_CS_N),
  .SQ_MISO_OE(SQ_MISO_OE), .SQ_CMD_VLD(SQ_CMD_VLD), .SOFT_RST(SOFT_RST), .SAT_CS_N(SAT_CS_N),
  .SAT_MISO_OE(SAT_MISO_OE), .SAT_CMD_VLD(SAT_CMD_VLD));

// >>> dssf_host.sv
`timescale 1ns/1ps
module dssf_host #(parameter W = 16) (
  output reg       sclk,
  output reg       cs_n,
  output reg       mosi,
  input wire logic miso_o,
  input wire logic miso_oe
);
  // A released line shows the inverse level, so stale data cannot pass.
  wire line = miso_oe ? miso_o : ~miso_o;
  initial begin
    sclk = 0;
    cs_n = 1;
    mosi = 0;
  end
  // select low, sample on rise, send MSB first
  task xfer(input integer n, input [W-1:0] d, output [W-1:0] q);
    integer i;
    begin
      q = 0;
      cs_n = 0;
      #40;
      for (i = 0; i < n; i = i + 1) begin
        mosi = (i < W) ? d[W-1-i] : 1'b0;
        #16 sclk = 1;
        q = {q[W-2:0], line};
        #16 sclk = 0;
      end
      #40 cs_n = 1;
      #700;
    end
  endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
`include "dssf_regs.vh"
module tb_top;
  reg         SYS_CLK = 0;
  reg         RST_N = 0;
  reg  [15:0] SQ_REPLY = 16'hA5C3;
  reg  [79:0] SAT_STATUS = 80'h0123_4567_89AB_CDEF_0247;
  wire        sq_sclk, sq_cs_n, sq_mosi, sq_o, sq_oe, sat_sclk, sat_cs_n, sat_mosi, sat_o, sat_oe;
  wire [15:0] SQ_CMD;
  wire [79:0] SAT_CMD;
  wire        SQ_CMD_VLD, SAT_CMD_VLD, SOFT_RST;
  integer     bad_count = 0, n_tests = 0, vld_n = 0, svld_n = 0, srst_n = 0;
  always #2 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    vld_n <= vld_n + SQ_CMD_VLD;
    svld_n <= svld_n + SAT_CMD_VLD;
    srst_n <= srst_n + SOFT_RST;
  end
  dssf_spi i_dssf_spi (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .SQ_SCLK(sq_sclk), .SQ_CS_N(sq_cs_n),
    .SQ_MOSI(sq_mosi), .SQ_MISO_O(sq_o), .SQ_MISO_OE(sq_oe), .SAT_SCLK(sat_sclk),
    .SAT_CS_N(sat_cs_n), .SAT_MOSI(sat_mosi), .SAT_MISO_O(sat_o), .SAT_MISO_OE(sat_oe),
    .SQ_REPLY(SQ_REPLY), .SQ_CMD(SQ_CMD), .SQ_CMD_VLD(SQ_CMD_VLD), .SAT_STATUS(SAT_STATUS),
    .SAT_CMD(SAT_CMD), .SAT_CMD_VLD(SAT_CMD_VLD), .SOFT_RST(SOFT_RST));
  dssf_host #(.W(16)) i_dssf_host_sq (.sclk(sq_sclk), .cs_n(sq_cs_n), .mosi(sq_mosi),
    .miso_o(sq_o), .miso_oe(sq_oe));
  dssf_host #(.W(80)) i_dssf_host_sat (.sclk(sat_sclk), .cs_n(sat_cs_n), .mosi(sat_mosi),
    .miso_o(sat_o), .miso_oe(sat_oe));
  task chk(input [79:0] g, input [79:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task end_of_test;
    begin
      if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task t_squib;
    reg [15:0] q;
    begin
      i_dssf_host_sq.xfer(16, 16'h1234, q);
      chk(q, `DSSF_SQ_RESET_VAL);
      chk(SQ_CMD, 16'h1234);
      i_dssf_host_sq.xfer(16, `DSSF_SQ_RST_CMD, q);
      chk(q, 16'hA5C3);
      chk({vld_n, srst_n}, {32'd1, 32'd1});
      i_dssf_host_sq.xfer(15, 16'h0F0F, q);
      chk(q, 16'hA5C3 >> 1);
      chk(vld_n, 1);
      // Seventeen edges: the last sample repeats the sixteenth bit of the fault word.
      i_dssf_host_sq.xfer(17, 16'h0001, q);
      chk(q, {`DSSF_SQ_FAULT, 1'b1} & 16'hFFFF);
      chk({vld_n, SQ_CMD}, {32'd1, 16'h1234});
    end
  endtask
  task t_sat;
    reg [79:0] q;
    reg [15:0] qs;
    begin
      fork
        i_dssf_host_sat.xfer(80, 80'hC3, q);
        i_dssf_host_sq.xfer(16, 16'h5555, qs);
      join
      chk(q, SAT_STATUS);
      chk(SAT_CMD, 80'hC3);
      chk(SQ_CMD, 16'h5555);
      chk(qs, `DSSF_SQ_FAULT);
      i_dssf_host_sat.xfer(79, 80'h77, q);
      i_dssf_host_sat.xfer(80, 80'h99, q);
      chk(q, {1'b1, SAT_STATUS[78:0]});
      chk(svld_n, 2);
      // Eighty-one edges: the last sample repeats the eightieth bit of the status.
      i_dssf_host_sat.xfer(81, 80'h55, q);
      chk(q, {SAT_STATUS[78:0], SAT_STATUS[0]});
      i_dssf_host_sq.xfer(16, `DSSF_SQ_RST_CMD, qs);
      i_dssf_host_sat.xfer(80, 80'h11, q);
      chk(q, SAT_STATUS);
      chk({svld_n, srst_n}, {32'd3, 32'd2});
    end
  endtask
  initial begin
    #200000;
    bad_count = bad_count + 1;
    end_of_test;
  end
  initial begin
    repeat (2) @(posedge SYS_CLK);
    @(negedge SYS_CLK) RST_N = 1;
    repeat (4) @(negedge SYS_CLK);
    t_squib;
    t_sat;
    end_of_test;
  end
endmodule
